// File: rtl/fpwm_oscillator.sv
// Jittered fixed-frequency oscillator with max-duty phase output.
// Assumes a synchronous clock; run low holds it at period start.
`timescale 1ns/1ps
module fpwm_oscillator #(
  parameter int unsigned CW = 12
) (
  input  wire logic          i_clk,      // Core clock
  input  wire logic          i_resetn,   // Sync reset, active low
  input  wire logic          i_run,      // Oscillator enabled
  input  wire logic          i_jitter,   // Jitter enabled
  output logic               o_start,    // One-cycle pulse at period start
  output logic               o_on_phase  // High in max-duty charge phase
);
  localparam int unsigned NOM = fpwm_pkg::PERIOD_NOM_CYC;
  localparam int unsigned DEV = fpwm_pkg::PERIOD_DEV_CYC;

  initial begin
    if ((1 << CW) <= fpwm_pkg::PERIOD_MAX_CYC)
      $error("fpwm_oscillator: CW too small for the period");
  end

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] period_reg;
  logic [CW-1:0] on_len;
  logic [7:0]    dwell_reg;
  logic          up_reg;
  logic          last;

  assign last   = (cnt_reg == period_reg - CW'(1));
  assign on_len = CW'(32'(period_reg) * fpwm_pkg::MAX_DUTY_LIMIT_NUM
                  / fpwm_pkg::MAX_DUTY_LIMIT_DEN);

  // [RULE_15] nominal period counter
  always_ff @(posedge i_clk) begin
    if (!i_resetn || !i_run)
      cnt_reg <= '0;
    else if (last)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_reg + CW'(1);
  end

  // [RULE_22] triangular period sweep
  always_ff @(posedge i_clk) begin
    if (!i_resetn || !i_jitter) begin
      period_reg <= CW'(NOM);
      up_reg     <= 1'b1;
      dwell_reg  <= '0;
    end else if (last) begin
      if (dwell_reg == 8'(fpwm_pkg::JIT_DWELL - 1)) begin
        dwell_reg <= '0;
        if (up_reg) begin
          if (period_reg == CW'(NOM + DEV)) begin
            up_reg     <= 1'b0;
            period_reg <= period_reg - CW'(1);
          end else
            period_reg <= period_reg + CW'(1);
        end else begin
          if (period_reg == CW'(NOM - DEV)) begin
            up_reg     <= 1'b1;
            period_reg <= period_reg + CW'(1);
          end else
            period_reg <= period_reg - CW'(1);
        end
      end else
        dwell_reg <= dwell_reg + 8'd1;
    end
  end

  // [RULE_17] max duty phase
  always_ff @(posedge i_clk) begin
    if (!i_resetn || !i_run) begin
      o_start    <= 1'b0;
      o_on_phase <= 1'b0;
    end else begin
      o_start    <= (cnt_reg == '0);
      o_on_phase <= (cnt_reg < on_len);
    end
  end
endmodule

// File: rtl/fpwm_pkg.sv
// Package for the flyback PWM sequencer: timing figures and cycle counts.
// Assumes a 20 MHz core clock; all cycle counts derive from that rate.
package fpwm_pkg;
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned CLK_PERIOD_NS   = 50;
  // Oscillator
  localparam int unsigned FSW_NOM_HZ      = 100_000;
  localparam int unsigned JITTER_PCT      = 4;
  localparam int unsigned JITTER_PERIOD_MS = 4;
  localparam int unsigned PERIOD_NOM_CYC  = CLK_HZ / FSW_NOM_HZ;
  localparam int unsigned PERIOD_DEV_CYC  = PERIOD_NOM_CYC * JITTER_PCT / 100;
  localparam int unsigned PERIOD_MIN_CYC  = PERIOD_NOM_CYC - PERIOD_DEV_CYC;
  localparam int unsigned PERIOD_MAX_CYC  = PERIOD_NOM_CYC + PERIOD_DEV_CYC;
  localparam int unsigned JIT_STEPS       = 2 * PERIOD_DEV_CYC;
  // Jitter period in switching periods, split over up and down sweep
  localparam int unsigned JIT_PERIODS =
    JITTER_PERIOD_MS * (FSW_NOM_HZ / 1000);
  localparam int unsigned JIT_DWELL = JIT_PERIODS / (2 * JIT_STEPS);
  // Max duty 0.75 as numerator over denominator
  localparam int unsigned MAX_DUTY_LIMIT_NUM        = 3;
  localparam int unsigned MAX_DUTY_LIMIT_DEN        = 4;
  // Minimum off-delay after pulse start (round down, at least one cycle)
  localparam int unsigned PULSE_DELAY_NS  = 156;
  localparam int unsigned PULSE_DELAY_CYC =
    (PULSE_DELAY_NS / CLK_PERIOD_NS) < 1 ? 1 : PULSE_DELAY_NS / CLK_PERIOD_NS;
  // Leading edge blanking (least times, round up)
  localparam int unsigned LEB_NORM_NS     = 220;
  localparam int unsigned LEB_BURST_NS    = 180;
  localparam int unsigned LEB_NORM_CYC    =
    (LEB_NORM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LEB_BURST_CYC   =
    (LEB_BURST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Soft start
  localparam int unsigned SS_STEPS        = 32;
  localparam int unsigned SS_STEP_US      = 300;
  localparam int unsigned SS_STEP_CYC     = CLK_HZ / 1_000_000 * SS_STEP_US;
  localparam int unsigned SS_TOTAL_MS     = 10;
  localparam int unsigned SS_TOTAL_CYC    = CLK_HZ / 1000 * SS_TOTAL_MS;
  // Reset values
  localparam logic [4:0]  SS_CODE_RST     = 5'h00;
endpackage

// File: rtl/fpwm_sequencer.sv
// Top of the flyback PWM sequencer: UVLO, soft start, pulse latch, gate.
// Assumes comparator inputs already synchronous to the 20 MHz clock.
//
// Operation
// [RULE_01] Startup path charges supply below on threshold
// [RULE_02] Above on: bias on, then startup off (code switches both in the same cycle)
// [RULE_03] Off only below off threshold; clear count
// [RULE_04] Auto-restart: bias off, resume after fault
// [RULE_05] Burst: bias mostly off, reference kept
// [RULE_06] Sense above feedback resets pulse latch
// [RULE_07] Sense amplifier applies fixed gain
// [RULE_08] Ramp switch closed in off phase
// [RULE_09] Gate held off fixed delay after start
// [RULE_10] Either comparator may end the pulse
// [RULE_11] Soft start begins at on threshold
// [RULE_12] Counter steps soft-start limit in 32 steps
// [RULE_13] Soft start ends at fixed time
// [RULE_14] Soft start reruns each restart attempt
// [RULE_15] Oscillator 100 kHz with jitter
// [RULE_16] Jitter only after soft start ends
// [RULE_17] Maximum duty cycle limited to 0.75
// [RULE_18] Oscillator sets latch; comparators clear it
// [RULE_19] Latch reset turns gate off at once
// [RULE_20] Gate low while supply below lockout
// [RULE_21] Blank sensing, shorter in burst
// [RULE_22] Jitter is triangular sweep
// [RULE_23] Latch reset wins over set
`timescale 1ns/1ps
module fpwm_sequencer #(
  parameter int unsigned SS_STEP_CYC  = fpwm_pkg::SS_STEP_CYC,
  parameter int unsigned SS_TOTAL_CYC = fpwm_pkg::SS_TOTAL_CYC
) (
  input  wire logic       I_CLK,          // 20 MHz clock
  input  wire logic       I_RESETN,       // Sync reset, active low
  input  wire logic       I_SUPPLY_ON,    // Supply above on threshold
  input  wire logic       I_SUPPLY_OFF,   // Supply below off threshold
  input  wire logic       I_AUTO_RESTART, // Fault: auto-restart active
  input  wire logic       I_BURST,        // Active burst mode
  input  wire logic       I_BURST_IDLE,   // Burst gap, no switching
  input  wire logic       I_PWM_CMP,      // Amplified sense above feedback
  input  wire logic       I_SS_CMP,       // Ramp above soft-start limit
  input  wire logic       I_ILIM_CMP,     // Sense above current limit
  output logic            O_STARTUP_EN,   // Startup charge path on
  output logic            O_BIAS_EN,      // Internal bias on
  output logic            O_VREF_EN,      // Voltage reference on
  output logic            O_SENSE_AMP_EN, // Sense amplifier gain active
  output logic            O_BLANK,        // Sense path blanked
  output logic            O_RAMP_RESET,   // Ramp reset switch closed
  output logic [4:0]      O_SS_CODE,      // Soft-start sink code
  output logic            O_SS_SINK_EN,   // Soft-start current sink on
  output logic            O_SS_DONE,      // Soft start finished
  output logic            O_GATE          // Gate drive
);
  initial begin
    if (SS_STEP_CYC < 1 || SS_TOTAL_CYC < SS_STEP_CYC)
      $error("fpwm_sequencer: soft-start counts out of range");
  end

  typedef enum logic [3:0] {
    FPWM_OFF     = 4'b0001,
    FPWM_BIASUP  = 4'b0010,
    FPWM_RUN     = 4'b0100,
    FPWM_RESTART = 4'b1000
  } fpwm_state_t;

  fpwm_state_t state_reg;
  logic [23:0] ss_tick_reg;
  logic [23:0] ss_time_reg;
  logic [4:0]  ss_code_reg;
  logic        ss_done_reg;
  logic        latch_reg;
  logic [3:0]  delay_reg;
  logic [3:0]  blank_reg;
  logic        osc_run;
  logic        osc_start;
  logic        osc_on;
  logic        terminate;
  logic        running;

  assign running = (state_reg == FPWM_RUN) && !I_BURST_IDLE;
  assign osc_run = (state_reg == FPWM_RUN);

  // [RULE_02] bias on and startup off in the same cycle
  // [RULE_03] off only on off threshold
  always_ff @(posedge I_CLK) begin
    if (!I_RESETN)
      state_reg <= FPWM_OFF;
    else begin
      unique case (state_reg)
        FPWM_OFF:
          if (I_SUPPLY_ON) state_reg <= FPWM_BIASUP;
        FPWM_BIASUP:
          if (I_SUPPLY_OFF) state_reg <= FPWM_OFF;
          else state_reg <= FPWM_RUN;
        FPWM_RUN:
          if (I_SUPPLY_OFF) state_reg <= FPWM_OFF;
          else if (I_AUTO_RESTART) state_reg <= FPWM_RESTART;
        FPWM_RESTART:
          // [RULE_04] recovery without line cycling
          if (I_SUPPLY_OFF) state_reg <= FPWM_OFF;
          else if (!I_AUTO_RESTART) state_reg <= FPWM_BIASUP;
        default:
          state_reg <= FPWM_OFF;
      endcase
    end
  end

  // [RULE_01] startup path below on
  // [RULE_05] bias off in burst gaps
  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      O_STARTUP_EN   <= 1'b1;
      O_BIAS_EN      <= 1'b0;
      O_VREF_EN      <= 1'b0;
      O_SENSE_AMP_EN <= 1'b0;
    end else begin
      O_STARTUP_EN   <= (state_reg == FPWM_OFF);
      O_BIAS_EN      <= (state_reg == FPWM_BIASUP) || running;
      O_VREF_EN      <= (state_reg == FPWM_BIASUP) ||
                        (state_reg == FPWM_RUN);
      // [RULE_07] gain stage on only while running, not in bias-up
      O_SENSE_AMP_EN <= running;
    end
  end

  // [RULE_11] soft start from switch-on
  // [RULE_12] step every interval
  // [RULE_14] rerun on restart
  always_ff @(posedge I_CLK) begin
    if (!I_RESETN || state_reg != FPWM_RUN) begin
      ss_tick_reg <= '0;
      ss_time_reg <= '0;
      ss_code_reg <= fpwm_pkg::SS_CODE_RST;
      ss_done_reg <= 1'b0;
    end else if (!ss_done_reg) begin
      ss_time_reg <= ss_time_reg + 24'd1;
      if (ss_tick_reg == 24'(SS_STEP_CYC - 1)) begin
        ss_tick_reg <= '0;
        if (ss_code_reg != 5'(fpwm_pkg::SS_STEPS - 1))
          ss_code_reg <= ss_code_reg + 5'd1;
      end else
        ss_tick_reg <= ss_tick_reg + 24'd1;
      // [RULE_13] finish at fixed time
      if (ss_time_reg == 24'(SS_TOTAL_CYC - 1))
        ss_done_reg <= 1'b1;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      O_SS_CODE    <= fpwm_pkg::SS_CODE_RST;
      O_SS_SINK_EN <= 1'b0;
      O_SS_DONE    <= 1'b0;
    end else begin
      O_SS_CODE    <= ss_code_reg;
      O_SS_SINK_EN <= osc_run && !ss_done_reg;
      O_SS_DONE    <= ss_done_reg;
    end
  end

  // [RULE_16] jitter gated by soft start
  fpwm_oscillator #(
    .CW (12)
  ) u_osc (
    .i_clk      (I_CLK),
    .i_resetn   (I_RESETN),
    .i_run      (osc_run),
    .i_jitter   (ss_done_reg),
    .o_start    (osc_start),
    .o_on_phase (osc_on)
  );

  // [RULE_21] blanking length by mode
  always_ff @(posedge I_CLK) begin
    if (!I_RESETN || !running)
      blank_reg <= '0;
    else if (osc_start)
      blank_reg <= I_BURST ? 4'(fpwm_pkg::LEB_BURST_CYC)
                           : 4'(fpwm_pkg::LEB_NORM_CYC);
    else if (blank_reg != '0)
      blank_reg <= blank_reg - 4'd1;
  end

  // [RULE_06] feedback compare ends pulse
  // [RULE_10] soft-start compare also ends
  assign terminate = (blank_reg == '0) && !osc_start &&
                     (I_PWM_CMP || I_SS_CMP || I_ILIM_CMP);

  // [RULE_18] oscillator sets latch
  // [RULE_23] reset beats set
  always_ff @(posedge I_CLK) begin
    if (!I_RESETN || !running)
      latch_reg <= 1'b0;
    else if (terminate || !osc_on)
      latch_reg <= 1'b0;
    else if (osc_start && !(I_PWM_CMP || I_SS_CMP || I_ILIM_CMP))
      latch_reg <= 1'b1;
  end

  // [RULE_09] minimum off delay
  always_ff @(posedge I_CLK) begin
    if (!I_RESETN || !running)
      delay_reg <= '0;
    else if (osc_start)
      delay_reg <= 4'(fpwm_pkg::PULSE_DELAY_CYC);
    else if (delay_reg != '0)
      delay_reg <= delay_reg - 4'd1;
  end

  // [RULE_19] gate off when latch reset
  // [RULE_20] gate low under lockout
  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      O_GATE       <= 1'b0;
      O_BLANK      <= 1'b1;
      O_RAMP_RESET <= 1'b1;
    end else begin
      // Drop with the on phase, not one cycle after the latch clears
      O_GATE       <= running && latch_reg && !terminate && osc_on &&
                      delay_reg == '0 && !I_SUPPLY_OFF;
      O_BLANK      <= blank_reg != '0 || osc_start;
      // [RULE_08] ramp switch follows off phase
      O_RAMP_RESET <= !osc_on;
    end
  end

  // [RULE_20] no drive below off threshold
  a_gate_lockout: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    state_reg == FPWM_OFF |=> !O_GATE)
    else $error("gate driven during lockout");
  // [RULE_19] latch reset turns gate off
  a_gate_latch: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    !latch_reg |=> !O_GATE)
    else $error("gate on without latch");
  // [RULE_09] delay after start
  a_start_delay: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    osc_start |=> !O_GATE [*2])
    else $error("gate on inside start delay");
  // [RULE_02] startup path released
  a_startup_off: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    state_reg == FPWM_RUN |=> !O_STARTUP_EN)
    else $error("startup path on in run");
  // [RULE_03] soft start cleared on off
  a_ss_clear: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    state_reg == FPWM_OFF |=> ss_code_reg == 5'h00)
    else $error("soft-start count not cleared");
  // [RULE_04] bias off in restart
  a_restart_bias: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    state_reg == FPWM_RESTART |=> !O_BIAS_EN)
    else $error("bias on in auto-restart");
  // [RULE_06] compare ends pulse
  sequence s_cut;
    latch_reg && terminate;
  endsequence
  a_cmp_cut: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    s_cut |=> !latch_reg ##0 !O_GATE)
    else $error("pulse not ended by comparator");
  // [RULE_13] soft start done by fixed time
  a_ss_done: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    ss_time_reg == 24'(SS_TOTAL_CYC - 1) && state_reg == FPWM_RUN
    |=> ss_done_reg)
    else $error("soft start not finished");
  // [RULE_08] ramp switch in off phase
  a_ramp_reset: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    !osc_on |=> O_RAMP_RESET)
    else $error("ramp switch open in off phase");
  // [RULE_17] no drive outside the on phase
  a_duty_cap: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    !osc_on |=> !O_GATE)
    else $error("gate on past max duty");
  // [RULE_21] comparators ignored while blanked
  a_blank_hold: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    running && latch_reg && osc_on && blank_reg != 4'h0 && !osc_start
    |=> latch_reg)
    else $error("pulse ended inside blanking");
  // [RULE_11] soft start from zero on entry
  sequence s_enter_run;
    state_reg == FPWM_BIASUP ##1 state_reg == FPWM_RUN;
  endsequence
  a_ss_begin: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    s_enter_run |=> O_SS_SINK_EN && O_SS_CODE == 5'h00)
    else $error("soft start not begun at switch-on");
  // [RULE_05] burst gap keeps the reference
  a_burst_ref: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    state_reg == FPWM_RUN && I_BURST_IDLE |=> !O_BIAS_EN && O_VREF_EN)
    else $error("burst gap bias or reference wrong");
endmodule

// File: test/fpwm_feedback_model.sv
// Sense ramp and comparator model standing in for the feedback network.
// Assumes the bench sets trip level and comparator choice between pulses.
`timescale 1ns/1ps
module fpwm_feedback_model (
  input  wire logic       i_clk,      // Core clock
  input  wire logic       i_gate,     // Gate drive from the device
  input  wire logic [7:0] i_level,    // On cycles before the trip
  input  wire logic [1:0] i_sel,      // 0 pwm, 1 soft start, 2 limit, 3 hold
  output logic            o_pwm_cmp,  // Sense above feedback level
  output logic            o_ss_cmp,   // Ramp above soft-start limit
  output logic            o_ilim_cmp  // Sense above current limit
);
  logic [7:0] ramp_reg = 8'h00;
  logic       trip;
  // Current only climbs while the switch conducts, as in a real primary
  always @(negedge i_clk) begin
    ramp_reg <= i_gate ? ramp_reg + 8'h01 : 8'h00;
  end
  // Hold mode keeps a comparator high to contest the latch set
  assign trip       = (i_sel == 2'h3) || (ramp_reg >= i_level);
  assign o_pwm_cmp  = trip && (i_sel == 2'h0 || i_sel == 2'h3);
  assign o_ss_cmp   = trip && (i_sel == 2'h1);
  assign o_ilim_cmp = trip && (i_sel == 2'h2);
endmodule

// File: test/testbench.sv
// Self-checking bench for the flyback PWM sequencer.
// Assumes shortened soft-start counts; inputs change at falling edges.
`timescale 1ns/1ps
module testbench;
  logic       I_CLK = 1'b0;
  logic       I_RESETN = 1'b0;
  logic       I_SUPPLY_ON = 1'b0;
  logic       I_SUPPLY_OFF = 1'b1;
  logic       I_AUTO_RESTART = 1'b0;
  logic       I_BURST = 1'b0;
  logic       I_BURST_IDLE = 1'b0;
  logic       pwm_cmp, ss_cmp, ilim_cmp;
  logic       O_STARTUP_EN, O_BIAS_EN, O_VREF_EN, O_SENSE_AMP_EN, O_BLANK;
  logic       O_RAMP_RESET, O_SS_SINK_EN, O_SS_DONE, O_GATE;
  logic [4:0] O_SS_CODE;
  logic [7:0] level = 8'd40;
  logic [1:0] sel = 2'h0;
  logic       rnd_on = 1'b0;
  logic       gate_q = 1'b0;
  int         fail_count = 0;
  int         samples_checked = 0;
  int         cyc = 0;
  int         high_cnt = 0;
  int         rises[$];
  always #25 I_CLK = ~I_CLK;
  fpwm_sequencer #(.SS_STEP_CYC(20), .SS_TOTAL_CYC(700)) fpwm_sequencer_i (
    .I_CLK(I_CLK), .I_RESETN(I_RESETN), .I_SUPPLY_ON(I_SUPPLY_ON),
    .I_SUPPLY_OFF(I_SUPPLY_OFF), .I_AUTO_RESTART(I_AUTO_RESTART),
    .I_BURST(I_BURST), .I_BURST_IDLE(I_BURST_IDLE), .I_PWM_CMP(pwm_cmp),
    .I_SS_CMP(ss_cmp), .I_ILIM_CMP(ilim_cmp), .O_STARTUP_EN(O_STARTUP_EN),
    .O_BIAS_EN(O_BIAS_EN), .O_VREF_EN(O_VREF_EN),
    .O_SENSE_AMP_EN(O_SENSE_AMP_EN), .O_BLANK(O_BLANK),
    .O_RAMP_RESET(O_RAMP_RESET), .O_SS_CODE(O_SS_CODE),
    .O_SS_SINK_EN(O_SS_SINK_EN), .O_SS_DONE(O_SS_DONE), .O_GATE(O_GATE));
  fpwm_feedback_model fpwm_feedback_model_i (
    .i_clk(I_CLK), .i_gate(O_GATE), .i_level(level), .i_sel(sel),
    .o_pwm_cmp(pwm_cmp), .o_ss_cmp(ss_cmp), .o_ilim_cmp(ilim_cmp));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge I_CLK);
  endtask

  // Wait for the start of an off phase, so no pulse is cut by the next step
  task automatic wait_off();
    for (int i = 0; i < 300 && O_RAMP_RESET !== 1'b0; i++) step(1);
    for (int i = 0; i < 300 && O_RAMP_RESET !== 1'b1; i++) step(1);
    if (O_RAMP_RESET !== 1'b1) begin
      fail_count++;
      print_verdict();
    end
  endtask

  // Pulse monitor: width against the model's trip level and duty cap
  always @(negedge I_CLK) begin
    cyc++;
    if (O_GATE === 1'b1) begin
      high_cnt++;
    end else if (high_cnt != 0) begin
      // Pulse width tracks trip level
      chk(high_cnt <= 150, 1);
      if (level < 140) begin
        chk(high_cnt >= level && high_cnt <= level + 3, 1);
      end
      high_cnt = 0;
      if (rnd_on) begin
        level = 8'($urandom_range(10, 160));
        sel = 2'($urandom_range(0, 2));
      end
    end
    if (O_GATE === 1'b1 && gate_q === 1'b0) begin
      rises.push_back(cyc);
      // Ramp switch open during drive
      chk(O_RAMP_RESET, 0);
    end
    gate_q = O_GATE;
  end

  initial begin
    int steps;
    int t0;
    int diff;
    int moved;
    logic [4:0] prev;
    void'($urandom(34985));
    step(20);
    I_RESETN = 1'b1;
    step(5);
    // Startup path on, gate held low
    chk(O_STARTUP_EN, 1);
    chk(O_GATE, 0);
    chk(O_BIAS_EN, 0);
    $display("test lockout done");
    I_SUPPLY_OFF = 1'b0;
    I_SUPPLY_ON = 1'b1;
    t0 = cyc;
    step(3);
    chk(O_BIAS_EN, 1);
    chk(O_STARTUP_EN, 0);
    chk(O_SS_SINK_EN, 1);
    chk(O_SS_CODE, 0);
    $display("test power up done");
    rnd_on = 1'b1;
    steps = 0;
    prev = O_SS_CODE;
    // Code advances one step at a time
    for (int i = 0; i < 900 && O_SS_DONE !== 1'b1; i++) begin
      step(1);
      if (O_SS_CODE !== prev) begin
        chk(O_SS_CODE, prev + 5'h01);
        steps++;
        prev = O_SS_CODE;
      end
    end
    if (O_SS_DONE !== 1'b1) begin
      fail_count++;
      print_verdict();
    end
    diff = cyc - t0;
    chk(diff >= 697 && diff <= 705, 1);
    chk(steps, 31);
    chk(O_SS_SINK_EN, 0);
    chk(rises.size() >= 3, 1);
    chk(rises[2] - rises[1], 200);
    $display("test soft start done");
    I_BURST = 1'b1;
    rises.delete();
    step(6500);
    moved = 0;
    for (int i = 1; i < rises.size(); i++) begin
      diff = rises[i] - rises[i - 1];
      chk(diff >= 192 && diff <= 208, 1);
      if (diff != 200) moved = 1;
    end
    chk(rises.size() > 25, 1);
    chk(moved, 1);
    I_BURST = 1'b0;
    $display("test jitter done");
    rnd_on = 1'b0;
    step(250);
    wait_off();
    sel = 2'h3;
    rises.delete();
    step(450);
    chk(rises.size(), 0);
    sel = 2'h0;
    $display("test latch priority done");
    wait_off();
    I_BURST_IDLE = 1'b1;
    step(4);
    chk(O_BIAS_EN, 0);
    chk(O_VREF_EN, 1);
    I_BURST_IDLE = 1'b0;
    $display("test burst done");
    wait_off();
    I_AUTO_RESTART = 1'b1;
    step(4);
    chk(O_BIAS_EN, 0);
    chk(O_GATE, 0);
    I_AUTO_RESTART = 1'b0;
    step(5);
    chk(O_BIAS_EN, 1);
    chk(O_SS_CODE, 0);
    chk(O_SS_DONE, 0);
    $display("test restart done");
    step(100);
    I_SUPPLY_ON = 1'b0;
    step(4);
    // Between thresholds bias must hold
    chk(O_BIAS_EN, 1);
    chk(O_SS_CODE != 5'h00, 1);
    wait_off();
    I_SUPPLY_OFF = 1'b1;
    step(4);
    chk(O_BIAS_EN, 0);
    chk(O_SS_CODE, 0);
    chk(O_GATE, 0);
    chk(O_STARTUP_EN, 1);
    $display("test supply off done");
    print_verdict();
  end
endmodule
